// ===== rtl/pmicie_pkg.sv
/*
 * Constants for the interrupt enable block of the display power device:
 * register offsets, reset values, writable masks and bit positions.
 * Assumes byte-wide register access from the serial control front end.
 */
// Overview of operation
// - An occurred event with enable 1 pulls the interrupt pin low.
// - An occurred event with enable 0 never pulls the pin low.
// - First enable register sits at 0x05 and resets to 7Fh.
// - Second enable register sits at 0x06 and resets to FFh.
// - First register bit 7, temperature-change enable, is read-only zero.
// - First register bit 6 enables thermal shutdown, writable, resets 1.
// - First reg bit 5 enables shutdown early warning, writable, resets 1.
// - First register bit 4 enables thermistor hot, writable, resets 1.
// - First register bit 3 enables thermistor cold, writable, resets 1.
// - First register bit 2 enables input undervoltage, writable, resets 1.
// - First register bit 1, bias measure done enable, read-only one.
// - First register bit 0, bias program done enable, read-only one.
// - Second register bit 7 enables boost undervoltage, writable, resets 1.
// - Second register bit 6 enables positive gate pump undervoltage.
// - Second reg bit 5 enables inverter undervoltage, writable, resets 1.
// - Second register bit 4 enables positive source regulator undervoltage.
// - Second register bit 3 enables negative gate pump undervoltage.
// - Second register bit 2 enables bias fault, writable, resets 1.
// - Second register bit 1 enables negative source regulator undervoltage.
// - Second register bit 0 enables temperature conversion done, resets 1.
// - Each enable bit gates the status flag at the same position.

package pmicie_pkg;

    localparam int          ADDR_W = 8;
    localparam int          DATA_W = 8;

    typedef logic [ADDR_W-1:0] pmicie_addr_t;
    typedef logic [DATA_W-1:0] pmicie_byte_t;

    ////////////////////////////////////////////////////////////////////////
    // register map
    localparam pmicie_addr_t ADDR_EN_THERMAL = 8'h05;
    localparam pmicie_addr_t ADDR_EN_RAIL    = 8'h06;

    localparam pmicie_byte_t RST_EN_THERMAL  = 8'h7f;
    localparam pmicie_byte_t RST_EN_RAIL     = 8'hff;

    // bits the host may change; the rest hold their reset value
    localparam pmicie_byte_t WMASK_EN_THERMAL = 8'h7c;
    localparam pmicie_byte_t WMASK_EN_RAIL    = 8'hff;

    localparam pmicie_byte_t RDATA_UNMAPPED  = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // first enable register fields
    localparam int BIT_TEMP_CHANGE    = 7;
    localparam int BIT_THERMAL_SHUT   = 6;
    localparam int BIT_THERMAL_WARN   = 5;
    localparam int BIT_THERMISTOR_HI  = 4;
    localparam int BIT_THERMISTOR_LO  = 3;
    localparam int BIT_INPUT_UV       = 2;
    localparam int BIT_BIAS_MEAS_DONE = 1;
    localparam int BIT_BIAS_PROG_DONE = 0;

    // second enable register fields
    localparam int BIT_BOOST_UV       = 7;
    localparam int BIT_POS_GATE_UV    = 6;
    localparam int BIT_INVERTER_UV    = 5;
    localparam int BIT_POS_SOURCE_UV  = 4;
    localparam int BIT_NEG_GATE_UV    = 3;
    localparam int BIT_BIAS_FAULT     = 2;
    localparam int BIT_NEG_SOURCE_UV  = 1;
    localparam int BIT_TEMP_CONV_DONE = 0;

endpackage

// ===== rtl/pmicie_enable_reg.sv
/*
 * One 8-bit interrupt enable register. Bits set in the write mask are
 * host-writable; the others never take a write and hold their reset value.
 * Assumes write strobe and data come from logic on the same clock.
 */
`timescale 1ns/1ps

module pmicie_enable_reg #(
    parameter pmicie_pkg::pmicie_byte_t RESET_VAL = 8'h00,
    parameter pmicie_pkg::pmicie_byte_t WR_MASK   = 8'h00
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    // write port
    input  wire logic                      wr_en,
    input  wire pmicie_pkg::pmicie_byte_t  wr_data,
    // register value
    output logic [pmicie_pkg::DATA_W-1:0]  value_r
);

    genvar i;
    generate
        for (i = 0; i < pmicie_pkg::DATA_W; i++) begin : g_bit
            // one kind of driver per vector: masked bits see no write,
            // so their read-back stays the reset value
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    value_r[i] <= RESET_VAL[i];
                end else if (wr_en && WR_MASK[i]) begin
                    value_r[i] <= wr_data[i];
                end
            end
        end
    endgenerate

endmodule

// ===== rtl/pmicie_top.sv
/*
 * Interrupt enable logic: two enable registers, the gating of event
 * status flags and the open-drain, active-low interrupt request pin.
 * Assumes the serial front end presents byte reads and writes as
 * one-cycle strobes on clk, and status flags come from same-clock logic.
 */
`timescale 1ns/1ps

module pmicie_top (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    // register access from the serial front end
    input  wire pmicie_pkg::pmicie_addr_t  reg_addr,
    input  wire logic                      reg_wr_en,
    input  wire logic                      reg_rd_en,
    input  wire pmicie_pkg::pmicie_byte_t  reg_wdata,
    output pmicie_pkg::pmicie_byte_t       reg_rdata,
    output logic                           reg_rdata_valid,
    // event status flags, one per enable bit
    input  wire pmicie_pkg::pmicie_byte_t  event_status_thermal_supply,
    input  wire pmicie_pkg::pmicie_byte_t  event_status_rail_faults,
    // open-drain interrupt request pin
    input  wire logic                      interrupt_request_out_low_in,
    output logic                           interrupt_request_out_low_out,
    output logic                           interrupt_request_out_low_oe_n,
    // synchronised pin level for the rest of the device
    output logic                           irq_pin_level
);

    ////////////////////////////////////////////////////////////////////////
    // enable registers

    pmicie_pkg::pmicie_byte_t event_enable_thermal_supply;
    pmicie_pkg::pmicie_byte_t event_enable_rail_faults;
    logic                     wr_thermal;
    logic                     wr_rail;

    assign wr_thermal = reg_wr_en
                        && (reg_addr == pmicie_pkg::ADDR_EN_THERMAL);
    assign wr_rail    = reg_wr_en
                        && (reg_addr == pmicie_pkg::ADDR_EN_RAIL);

    // bits 7, 1 and 0 are outside the mask: fixed 0, 1, 1
    pmicie_enable_reg #(
        .RESET_VAL (pmicie_pkg::RST_EN_THERMAL),
        .WR_MASK   (pmicie_pkg::WMASK_EN_THERMAL)
    ) u_en_thermal (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (wr_thermal),
        .wr_data (reg_wdata),
        .value_r (event_enable_thermal_supply)
    );

    pmicie_enable_reg #(
        .RESET_VAL (pmicie_pkg::RST_EN_RAIL),
        .WR_MASK   (pmicie_pkg::WMASK_EN_RAIL)
    ) u_en_rail (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (wr_rail),
        .wr_data (reg_wdata),
        .value_r (event_enable_rail_faults)
    );

    ////////////////////////////////////////////////////////////////////////
    // read path: data one cycle after the strobe

    pmicie_pkg::pmicie_byte_t rdata_nxt;
    pmicie_pkg::pmicie_byte_t rdata_r;
    logic                     rvalid_r;

    always_comb begin
        case (reg_addr)
            pmicie_pkg::ADDR_EN_THERMAL:
                rdata_nxt = event_enable_thermal_supply;
            pmicie_pkg::ADDR_EN_RAIL:
                rdata_nxt = event_enable_rail_faults;
            default:
                rdata_nxt = pmicie_pkg::RDATA_UNMAPPED;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= pmicie_pkg::RDATA_UNMAPPED;
        end else if (reg_rd_en) begin
            rdata_r <= rdata_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_rd_en;
        end
    end

    assign reg_rdata       = rdata_r;
    assign reg_rdata_valid = rvalid_r;

    ////////////////////////////////////////////////////////////////////////
    // interrupt gating

    pmicie_pkg::pmicie_byte_t gated_thermal;
    pmicie_pkg::pmicie_byte_t gated_rail;
    logic                     irq_pending;
    logic                     oe_n_r;
    logic                     pin_out_r;

    // same bit position pairs flag with its enable
    assign gated_thermal = event_status_thermal_supply
                           & event_enable_thermal_supply;
    assign gated_rail    = event_status_rail_faults
                           & event_enable_rail_faults;
    assign irq_pending   = (|gated_thermal) || (|gated_rail);

    // level, not latched: the status flags are sticky upstream
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oe_n_r <= 1'b1;
        end else begin
            oe_n_r <= ~irq_pending;
        end
    end

    // open drain: only ever drives low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_out_r <= 1'b0;
        end else begin
            pin_out_r <= 1'b0;
        end
    end

    assign interrupt_request_out_low_out  = pin_out_r;
    assign interrupt_request_out_low_oe_n = oe_n_r;

    ////////////////////////////////////////////////////////////////////////
    // pin level synchroniser; wired-or with other sources on the board

    logic pin_meta_r;
    logic pin_sync_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_meta_r <= 1'b1;
            pin_sync_r <= 1'b1;
        end else begin
            pin_meta_r <= interrupt_request_out_low_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    assign irq_pin_level = pin_sync_r;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    sequence s_wr_thermal;
        reg_wr_en && (reg_addr == pmicie_pkg::ADDR_EN_THERMAL);
    endsequence

    sequence s_wr_rail;
        reg_wr_en && (reg_addr == pmicie_pkg::ADDR_EN_RAIL);
    endsequence

    sequence s_rd_thermal;
        reg_rd_en && (reg_addr == pmicie_pkg::ADDR_EN_THERMAL);
    endsequence

    sequence s_rd_unmapped;
        reg_rd_en && (reg_addr != pmicie_pkg::ADDR_EN_THERMAL)
                  && (reg_addr != pmicie_pkg::ADDR_EN_RAIL);
    endsequence

    sequence s_enabled_event;
        ((event_status_thermal_supply & event_enable_thermal_supply) != 0)
        || ((event_status_rail_faults & event_enable_rail_faults) != 0);
    endsequence

    a_irq_drive_low: assert property (
        @(posedge clk) disable iff (rst)
        s_enabled_event |=> !interrupt_request_out_low_oe_n
    ) else $error("enabled event did not pull the interrupt pin low");

    a_irq_masked_off: assert property (
        @(posedge clk) disable iff (rst)
        !((|(event_status_thermal_supply & event_enable_thermal_supply))
          || (|(event_status_rail_faults & event_enable_rail_faults)))
        |=> interrupt_request_out_low_oe_n
    ) else $error("interrupt pin low with no enabled event");

    a_flag_gate_bit: assert property (
        @(posedge clk) disable iff (rst)
        (event_status_rail_faults ==
            pmicie_pkg::pmicie_byte_t'(1 << pmicie_pkg::BIT_BIAS_FAULT))
        && (event_status_thermal_supply == 8'h00)
        |=> (interrupt_request_out_low_oe_n
             == !$past(event_enable_rail_faults[pmicie_pkg::BIT_BIAS_FAULT]))
    ) else $error("bias fault flag not gated by its own enable bit");

    a_reset_values: assert property (
        @(posedge clk)
        rst |=> (event_enable_thermal_supply == pmicie_pkg::RST_EN_THERMAL)
                && (event_enable_rail_faults == pmicie_pkg::RST_EN_RAIL)
                && interrupt_request_out_low_oe_n
    ) else $error("enable registers not at reset values after reset");

    a_ro_fixed_bits: assert property (
        @(posedge clk) disable iff (rst)
        s_wr_thermal |=>
            !event_enable_thermal_supply[pmicie_pkg::BIT_TEMP_CHANGE]
            && event_enable_thermal_supply[pmicie_pkg::BIT_BIAS_MEAS_DONE]
            && event_enable_thermal_supply[pmicie_pkg::BIT_BIAS_PROG_DONE]
    ) else $error("read-only enable bit changed by a write");

    a_thermal_write: assert property (
        @(posedge clk) disable iff (rst)
        s_wr_thermal |=>
            ((event_enable_thermal_supply & pmicie_pkg::WMASK_EN_THERMAL)
             == ($past(reg_wdata) & pmicie_pkg::WMASK_EN_THERMAL))
    ) else $error("writable bits of first enable register not updated");

    a_rail_write: assert property (
        @(posedge clk) disable iff (rst)
        s_wr_rail |=> (event_enable_rail_faults == $past(reg_wdata))
    ) else $error("second enable register not updated by write");

    a_rail_hold: assert property (
        @(posedge clk) disable iff (rst)
        !reg_wr_en ##1 1'b1 |-> $stable(event_enable_rail_faults)
    ) else $error("second enable register changed without a write");

    a_read_back: assert property (
        @(posedge clk) disable iff (rst)
        s_rd_thermal ##1 rvalid_r |->
            (reg_rdata == $past(event_enable_thermal_supply))
            && !reg_rdata[pmicie_pkg::BIT_TEMP_CHANGE]
    ) else $error("read of first enable register returned wrong data");

    a_read_unmapped: assert property (
        @(posedge clk) disable iff (rst)
        s_rd_unmapped |=> reg_rdata_valid
                          && (reg_rdata == pmicie_pkg::RDATA_UNMAPPED)
    ) else $error("unmapped read did not return zero");

    a_write_to_irq: assert property (
        @(posedge clk) disable iff (rst)
        s_wr_rail ##0 (reg_wdata == 8'h00)
        ##1 (event_status_thermal_supply == 8'h00)
        |=> interrupt_request_out_low_oe_n
    ) else $error("masking all rail enables left the pin driven");

    a_pin_drive_zero: assert property (
        @(posedge clk) disable iff (rst)
        !interrupt_request_out_low_oe_n |-> !interrupt_request_out_low_out
    ) else $error("interrupt pin driven high");

endmodule

// ===== verification/pmicie_host_model.sv
/*
 * Host side of the interrupt enable block: byte register accesses
 * and the pulled-up open-drain interrupt line.
 * Assumes the device samples strobes on the rising edge of clk.
 */
`timescale 1ns/1ps

module pmicie_host_model (
    // clock
    input  wire logic                      clk,
    // register port towards the device
    output pmicie_pkg::pmicie_addr_t       reg_addr,
    output logic                           reg_wr_en,
    output logic                           reg_rd_en,
    output pmicie_pkg::pmicie_byte_t       reg_wdata,
    input  wire pmicie_pkg::pmicie_byte_t  reg_rdata,
    input  wire logic                      reg_rdata_valid,
    // open-drain interrupt line
    input  wire logic                      pin_out,
    input  wire logic                      pin_oe_n,
    output logic                           pin_wire
);

    // board pull-up; the line only goes low while the device drives it
    assign pin_wire = (pin_oe_n === 1'b0) ? pin_out : 1'b1;

    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input pmicie_pkg::pmicie_addr_t a,
                      input pmicie_pkg::pmicie_byte_t d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(posedge clk);
        #1;
        reg_wr_en = 1'b0;
        // stale values would hide a strobe that is not qualified
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    task automatic rd(input pmicie_pkg::pmicie_addr_t a,
                      output pmicie_pkg::pmicie_byte_t d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(posedge clk);
        #1;
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        // read answer comes exactly one cycle after the strobe
        d = (reg_rdata_valid === 1'b1) ? reg_rdata : 8'hxx;
    endtask

endmodule

// ===== verification/tb_pmic_interrupt_enable_mask.sv
/*
 * Self-checking bench for the interrupt enable block: reset values,
 * write masks, per-bit gating of the interrupt line and mid-run reset.
 * Assumes the host model drives the register port and the pull-up.
 */
`timescale 1ns/1ps

module tb_pmic_interrupt_enable_mask;

    logic                      clk;
    logic                      rst;
    pmicie_pkg::pmicie_addr_t  reg_addr;
    logic                      reg_wr_en;
    logic                      reg_rd_en;
    pmicie_pkg::pmicie_byte_t  reg_wdata;
    pmicie_pkg::pmicie_byte_t  reg_rdata;
    logic                      reg_rdata_valid;
    pmicie_pkg::pmicie_byte_t  st_thermal;
    pmicie_pkg::pmicie_byte_t  st_rail;
    logic                      pin_out;
    logic                      pin_oe_n;
    logic                      pin_wire;
    logic                      irq_pin_level;
    int                        mismatches;
    int                        tests_run;

    pmicie_top pmicie_top_i (
        .clk                            (clk),
        .rst                            (rst),
        .reg_addr                       (reg_addr),
        .reg_wr_en                      (reg_wr_en),
        .reg_rd_en                      (reg_rd_en),
        .reg_wdata                      (reg_wdata),
        .reg_rdata                      (reg_rdata),
        .reg_rdata_valid                (reg_rdata_valid),
        .event_status_thermal_supply    (st_thermal),
        .event_status_rail_faults       (st_rail),
        .interrupt_request_out_low_in   (pin_wire),
        .interrupt_request_out_low_out  (pin_out),
        .interrupt_request_out_low_oe_n (pin_oe_n),
        .irq_pin_level                  (irq_pin_level)
    );

    pmicie_host_model pmicie_host_model_i (
        .clk             (clk),
        .reg_addr        (reg_addr),
        .reg_wr_en       (reg_wr_en),
        .reg_rd_en       (reg_rd_en),
        .reg_wdata       (reg_wdata),
        .reg_rdata       (reg_rdata),
        .reg_rdata_valid (reg_rdata_valid),
        .pin_out         (pin_out),
        .pin_oe_n        (pin_oe_n),
        .pin_wire        (pin_wire)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask

    task automatic rd_chk(input pmicie_pkg::pmicie_addr_t a,
                          input pmicie_pkg::pmicie_byte_t exp);
        pmicie_pkg::pmicie_byte_t d;
        pmicie_host_model_i.rd(a, d);
        chk(d, exp, "register read");
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic check_reset_values();
        rd_chk(pmicie_pkg::ADDR_EN_THERMAL, 8'h7f);
        rd_chk(pmicie_pkg::ADDR_EN_RAIL, 8'hff);
        rd_chk(8'h07, 8'h00);
        chk({7'h00, pin_oe_n}, 8'h01, "line idle");
    endtask

    task automatic check_write_masks();
        pmicie_host_model_i.wr(pmicie_pkg::ADDR_EN_THERMAL, 8'h00);
        rd_chk(pmicie_pkg::ADDR_EN_THERMAL, 8'h03);
        pmicie_host_model_i.wr(pmicie_pkg::ADDR_EN_THERMAL, 8'hff);
        rd_chk(pmicie_pkg::ADDR_EN_THERMAL, 8'h7f);
        rd_chk(pmicie_pkg::ADDR_EN_THERMAL, 8'h7f);
        pmicie_host_model_i.wr(pmicie_pkg::ADDR_EN_RAIL, 8'h00);
        rd_chk(pmicie_pkg::ADDR_EN_RAIL, 8'h00);
        pmicie_host_model_i.wr(8'h07, 8'h00);
        rd_chk(pmicie_pkg::ADDR_EN_THERMAL, 8'h7f);
        pmicie_host_model_i.wr(pmicie_pkg::ADDR_EN_RAIL, 8'hff);
        rd_chk(pmicie_pkg::ADDR_EN_RAIL, 8'hff);
    endtask

    // one flag alone, first with only its enable set, then all but it
    task automatic check_gate_bit(input int r, input int b);
        pmicie_pkg::pmicie_addr_t a;
        pmicie_pkg::pmicie_byte_t m;
        pmicie_pkg::pmicie_byte_t en;
        pmicie_pkg::pmicie_byte_t exp_oe;
        a = (r == 0) ? pmicie_pkg::ADDR_EN_THERMAL : pmicie_pkg::ADDR_EN_RAIL;
        m = 8'h01 << b;
        for (int k = 0; k < 2; k++) begin
            en = (k == 0) ? m : ~m;
            pmicie_host_model_i.wr(a, en);
            if (r == 0) begin
                en = (en & 8'h7c) | 8'h03;
                st_thermal = m;
            end else begin
                st_rail = m;
            end
            repeat (4) @(posedge clk);
            #1;
            exp_oe = {7'h00, ~|(en & m)};
            chk({7'h00, pin_oe_n}, exp_oe, "drive");
            chk({7'h00, irq_pin_level}, exp_oe, "level");
            chk({7'h00, pin_out}, 8'h00, "drive value");
            st_thermal = 8'h00;
            st_rail = 8'h00;
        end
        pmicie_host_model_i.wr(a, 8'hff);
    endtask

    // masking a flag that is already set releases the line
    task automatic check_mask_live();
        st_rail = 8'hff;
        repeat (3) @(posedge clk);
        #1;
        chk({7'h00, pin_oe_n}, 8'h00, "all flags");
        pmicie_host_model_i.wr(pmicie_pkg::ADDR_EN_RAIL, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        chk({7'h00, pin_oe_n}, 8'h01, "masked live");
        st_rail = 8'h00;
    endtask

    task automatic check_mid_reset();
        pmicie_host_model_i.wr(pmicie_pkg::ADDR_EN_THERMAL, 8'h00);
        @(posedge clk);
        #1;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        rd_chk(pmicie_pkg::ADDR_EN_THERMAL, 8'h7f);
        rd_chk(pmicie_pkg::ADDR_EN_RAIL, 8'hff);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        mismatches = 0;
        tests_run = 0;
        rst = 1'b1;
        st_thermal = 8'h00;
        st_rail = 8'h00;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        check_reset_values();
        check_write_masks();
        for (int r = 0; r < 2; r++) begin
            for (int b = 0; b < 8; b++) begin
                check_gate_bit(r, b);
            end
        end
        check_mask_live();
        check_mid_reset();
        wrap_up();
    end

    // run needs about 14 us; a hang is cut off well after that
    initial begin
        #200000;
        mismatches++;
        $display("wrong value at %0t: watchdog expired", $time);
        wrap_up();
    end

endmodule
